//--- rtl/loop_param_defs.vh
// Purpose: Constants for the heater loop parameter block
// Assumes: Register words are 32 bits, addressed by word index
// Notes:   Values are in tenths, hundredths or ten-thousandths
`ifndef LOOP_PARAM_DEFS_VH
`define LOOP_PARAM_DEFS_VH

// ****************************************
// Register word indices
// ****************************************
`define ADDR_HEATER_SETUP    3'h0
`define ADDR_PROP_GAIN       3'h1
`define ADDR_INTEGRAL        3'h2
`define ADDR_DERIVATIVE      3'h3
`define ADDR_BASELINE_OUTPUT 3'h4
`define ADDR_TARGET_VALUE    3'h5
`define ADDR_STATUS          3'h6
`define ADDR_TIMES           3'h7

// ****************************************
// Heater setup fields
// ****************************************
`define SETUP_MODE_LSB  0
`define SETUP_MODE_MSB  2
`define SETUP_SEL_LSB   4
`define SETUP_SEL_MSB   6
`define SETUP_UNITS_BIT 8
`define SETUP_DISP_BIT  9

// ****************************************
// Output modes
// ****************************************
`define MODE_OFF     3'h0
`define MODE_PID     3'h1
`define MODE_ZONE    3'h2
`define MODE_OPEN    3'h3
`define MODE_WARMUP  3'h4
`define MODE_MONITOR 3'h5

// ****************************************
// Limits and reset values
// ****************************************
`define GAIN_MAX     14'h2710
`define GAIN_RST     14'h01F4
`define INTEG_RST    14'h00C8
`define DERIV_MAX    8'hC8
`define DERIV_RST    8'h00
`define OUT_FULL     14'h2710
`define OUT_RST      14'h0000
`define TARGET_VALUE_COMMAND_RST     32'h00000000
`define TI_NUMER     17'h186A0
`define TD_DIVISOR   25'h0000190
`define DIV_STEPS    5'h11

`endif

//--- rtl/loop_param_ctrl.v
// Purpose: Parameter store and output computation for one heater loop
// Assumes: All inputs synchronous to clk; pid_term comes from the loop
//          arithmetic in hundredths of a percent of full scale
// Notes:   Writes are dropped while the divider or a conversion runs, except the heater_off clear by a setup write
`timescale 1ns/1ps
`default_nettype none
`include "loop_param_defs.vh"

module loop_param_ctrl #(
  parameter LOOP_ID = 1                 // Output number 1..4
) (
  input  wire        clk,               // System clock
  input  wire        srst,              // Synchronous reset
  input  wire [2:0]  addr,              // Register word index
  input  wire [31:0] wdata,             // Write data
  input  wire        wr_stb,            // Write strobe
  input  wire        rd_stb,            // Read strobe
  output reg  [31:0] rdata,             // Read data, next cycle
  input  wire [127:0] sensor_rd,        // Four readings, input one low
  input  wire [31:0] curve_sp_limit,    // Curve setpoint limit
  input  wire [31:0] sens_min,          // Sensor lower limit
  input  wire [31:0] sens_max,          // Sensor upper limit
  input  wire [31:0] sens_res,          // Sensor display step
  input  wire [31:0] temp_limit,        // Temperature limit
  input  wire        temp_limit_en,     // Temperature limit on
  input  wire signed [17:0] pid_term,   // PID result, 0.01 %
  input  wire        conv_ack,          // Curve conversion done
  input  wire [31:0] conv_result,       // Converted setpoint
  output reg  [15:0] out_level,         // Output to stage
  output reg  [31:0] feedback_value,    // Selected reading
  output reg         loop_active,       // Closed loop running
  output reg         integral_en,       // Integral term enabled
  output reg  [16:0] ti_tenths,         // Integral time, 0.1 s
  output reg  [16:0] td_tenths,         // Derivative time, 0.1 s
  output reg  [13:0] prop_gain,         // Gain in tenths
  output reg         ramp_allowed,      // Ramping may run
  output reg         disp_power,        // Percent of power
  output reg         heater_off,        // Limit trip latched
  output reg         conv_req,          // Conversion request
  output reg         conv_to_sensor,    // Convert toward sensor
  output reg  [31:0] conv_value         // Value to convert
);

  // ****************************************
  // Constants and helpers
  // ****************************************
  // Default input per output number; one-hot sequencer states
  localparam [2:0] SEL_RST = (LOOP_ID == 1) ? 3'h1 :
                             (LOOP_ID == 2) ? 3'h2 : 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_DIV  = 3'h2;
  localparam [2:0] ST_CONV = 3'h4;

  // Clamp a setpoint to unit bounds and snap sensor values to step
  function [31:0] clamp_sp;
    input [31:0] v;
    input        in_sensor;
    input [31:0] lim;
    input [31:0] lo;
    input [31:0] hi;
    input [31:0] res;
    reg   [31:0] t;
    begin
      t = v;
      if (in_sensor) begin
        if (t < lo) t = lo;
        if (t > hi) t = hi;
        if (res != 32'h00000000) t = t - (t % res);
      end else if (t > lim) begin
        t = lim;
      end
      clamp_sp = t;
    end
  endfunction

  // Limit a tenths or hundredths value to its top
  function [13:0] cap14;
    input [31:0] v;
    input [13:0] top;
    begin
      cap14 = (v > {18'h00000, top}) ? top : v[13:0];
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  // Stored settings, divider and sequencer
  reg  [2:0]  mode_reg;
  reg  [2:0]  sel_reg;
  reg         units_sensor_reg;
  reg  [13:0] integ_reg;
  reg  [7:0]  deriv_reg;
  reg  [13:0] baseline_output_command_reg;
  reg  [31:0] target_value_command_reg;
  reg  [2:0]  state_reg;
  reg  [17:0] rem_reg;
  reg  [16:0] quo_reg;
  reg  [4:0]  cnt_reg;
  // Decodes and combinational results
  wire [3:0]  over_lim;
  wire        busy;
  wire        closed_mode;
  wire        loop_ok;
  wire [31:0] sel_read;
  wire        new_units;
  reg  [15:0] level_next;
  reg  signed [18:0] sum;
  reg  [17:0] rem_sh;
  reg  [24:0] td_full;

  // ****************************************
  // Feedback selection and limit compare
  // ****************************************
  // Assigned reading, zero when no input is assigned
  assign sel_read = (sel_reg == 3'h0 || sel_reg > 3'h4) ? 32'h00000000 :
                    sensor_rd[(sel_reg - 3'h1) * 32 +: 32];
  // A closed mode forms a loop only with an assigned input
  assign closed_mode = (mode_reg == `MODE_PID) ||
                       (mode_reg == `MODE_ZONE) ||
                       (mode_reg == `MODE_WARMUP);
  assign loop_ok = closed_mode && (sel_reg != 3'h0);
  assign new_units = wdata[`SETUP_UNITS_BIT];
  // Writes are held off while dividing or converting, except the heater_off clear by a setup write
  assign busy = (state_reg != ST_IDLE);

  // Any reading above the limit trips every heater output
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lim
      assign over_lim[gi] = temp_limit_en &&
                            (sensor_rd[gi*32 +: 32] > temp_limit);
    end
  endgenerate

  // ****************************************
  // Output computation
  // ****************************************
  // Select and saturate the value sent to the output stage
  always @* begin
    // Baseline output plus PID result, signed
    sum = $signed({5'h00, baseline_output_command_reg}) + pid_term;
    // Derivative time: integral time times percent over 400
    td_full = ({8'h00, ti_tenths} * {17'h00000, deriv_reg}) /
              `TD_DIVISOR;
    level_next = 16'h0000;
    case (mode_reg)
      `MODE_OFF: level_next = 16'h0000;
      `MODE_OPEN: level_next = {2'h0, baseline_output_command_reg};
      `MODE_MONITOR: begin
        if (sel_reg != 3'h0) level_next = sel_read[15:0];
      end
      `MODE_PID, `MODE_ZONE, `MODE_WARMUP: begin
        if (!loop_ok) level_next = 16'h0000;
        else if (sum < 0) level_next = 16'h0000;
        else if (sum > $signed({5'h00, `OUT_FULL}))
          level_next = {2'h0, `OUT_FULL};
        else level_next = sum[15:0];
      end
      default: level_next = 16'h0000;
    endcase
    // A latched trip forces zero in every mode except monitor
    if (heater_off && mode_reg != `MODE_MONITOR)
      level_next = 16'h0000;
    // Next partial remainder of the divider
    rem_sh = {rem_reg[16:0], quo_reg[16]};
  end

  // Register outputs to the loop arithmetic and output stage
  always @(posedge clk) begin
    if (srst) begin
      out_level      <= 16'h0000;
      feedback_value <= 32'h00000000;
      loop_active    <= 1'b0;
      // Integral starts enabled since its reset setting is nonzero
      integral_en    <= 1'b1;
      td_tenths      <= 17'h00000;
      ramp_allowed   <= 1'b0;
      heater_off     <= 1'b0;
    end else begin
      out_level      <= level_next;
      feedback_value <= sel_read;
      loop_active    <= loop_ok;
      integral_en    <= (integ_reg != 14'h0000);
      td_tenths      <= td_full[16:0];
      ramp_allowed   <= loop_ok && !units_sensor_reg;
      // Set wins over the clear by a heater setup write
      if (|over_lim) heater_off <= 1'b1;
      else if (wr_stb && addr == `ADDR_HEATER_SETUP)
        heater_off <= 1'b0;
    end
  end

  // ****************************************
  // Register writes, divider and conversion
  // ****************************************
  always @(posedge clk) begin
    if (srst) begin
      // Reset settings; the divider runs once on release
      mode_reg         <= `MODE_OFF;
      sel_reg          <= SEL_RST;
      units_sensor_reg <= 1'b0;
      disp_power       <= 1'b0;
      prop_gain        <= `GAIN_RST;
      integ_reg        <= `INTEG_RST;
      deriv_reg        <= `DERIV_RST;
      baseline_output_command_reg         <= `OUT_RST;
      target_value_command_reg         <= `TARGET_VALUE_COMMAND_RST;
      state_reg        <= ST_DIV;
      rem_reg          <= 18'h00000;
      quo_reg          <= `TI_NUMER;
      cnt_reg          <= `DIV_STEPS;
      ti_tenths        <= 17'h00000;
      conv_req         <= 1'b0;
      conv_to_sensor   <= 1'b0;
      conv_value       <= 32'h00000000;
    end else begin
      // Conversion request is a one-cycle pulse
      conv_req <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (wr_stb) begin
            case (addr)
              `ADDR_HEATER_SETUP: begin
                mode_reg   <= wdata[`SETUP_MODE_MSB:`SETUP_MODE_LSB];
                sel_reg    <= wdata[`SETUP_SEL_MSB:`SETUP_SEL_LSB];
                disp_power <= wdata[`SETUP_DISP_BIT];
                if (new_units != units_sensor_reg) begin
                  units_sensor_reg <= new_units;
                  conv_req         <= 1'b1;
                  conv_to_sensor   <= new_units;
                  conv_value       <= target_value_command_reg;
                  state_reg        <= ST_CONV;
                end
              end
              // Values above range are capped, not refused
              `ADDR_PROP_GAIN:
                prop_gain <= cap14(wdata, `GAIN_MAX);
              // A new integral setting restarts the divider
              `ADDR_INTEGRAL: begin
                integ_reg <= cap14(wdata, `GAIN_MAX);
                rem_reg   <= 18'h00000;
                quo_reg   <= `TI_NUMER;
                cnt_reg   <= `DIV_STEPS;
                state_reg <= ST_DIV;
              end
              `ADDR_DERIVATIVE:
                deriv_reg <= (wdata > {24'h000000, `DERIV_MAX}) ?
                             `DERIV_MAX : wdata[7:0];
              `ADDR_BASELINE_OUTPUT:
                baseline_output_command_reg <= cap14(wdata, `OUT_FULL);
              // Setpoint clamped in the units now in force
              `ADDR_TARGET_VALUE:
                target_value_command_reg <= clamp_sp(wdata, units_sensor_reg,
                            curve_sp_limit, sens_min, sens_max,
                            sens_res);
              default: ;
            endcase
          end
        end
        ST_DIV: begin
          // Restoring divide: integral time = 100000 / setting
          if (integ_reg == 14'h0000) begin
            ti_tenths <= 17'h00000;
            state_reg <= ST_IDLE;
          end else if (cnt_reg == 5'h00) begin
            ti_tenths <= quo_reg;
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 5'h01;
            if (rem_sh >= {4'h0, integ_reg}) begin
              rem_reg <= rem_sh - {4'h0, integ_reg};
              quo_reg <= {quo_reg[15:0], 1'b1};
            end else begin
              rem_reg <= rem_sh;
              quo_reg <= {quo_reg[15:0], 1'b0};
            end
          end
        end
        ST_CONV: begin
          // Hold writes off until the curve returns the new setpoint
          if (conv_ack) begin
            target_value_command_reg  <= clamp_sp(conv_result, units_sensor_reg,
                         curve_sp_limit, sens_min, sens_max,
                         sens_res);
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  // Read data stands one cycle after the read strobe only
  always @(posedge clk) begin
    if (srst) begin
      rdata <= 32'h00000000;
    end else if (rd_stb) begin
      case (addr)
        `ADDR_HEATER_SETUP: rdata <= {22'h000000, disp_power,
                            units_sensor_reg, 1'b0, sel_reg,
                            1'b0, mode_reg};
        `ADDR_PROP_GAIN:       rdata <= {18'h00000, prop_gain};
        `ADDR_INTEGRAL:        rdata <= {18'h00000, integ_reg};
        `ADDR_DERIVATIVE:      rdata <= {24'h000000, deriv_reg};
        `ADDR_BASELINE_OUTPUT: rdata <= {18'h00000, baseline_output_command_reg};
        `ADDR_TARGET_VALUE:    rdata <= target_value_command_reg;
        // Status and times are read-only views
        `ADDR_STATUS: rdata <= {out_level, 11'h000, busy, heater_off,
                       ramp_allowed, integral_en, loop_active};
        `ADDR_TIMES:  rdata <= {15'h0000, ti_tenths};
        default:      rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end

endmodule // loop_param_ctrl
`default_nettype wire

//--- verif/loop_param_ctrl_asserts.sv
// Purpose: Timing checks on the heater loop parameter block ports
// Assumes: One clock domain, srst synchronous and active high
// Notes:   Bound to every loop_param_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module loop_param_ctrl_asserts (
  input wire logic         clk,            // System clock
  input wire logic         srst,           // Synchronous reset
  input wire logic [2:0]   addr,           // Word index
  input wire logic         rd_stb,         // Read strobe
  input wire logic [31:0]  rdata,          // Read data
  input wire logic [127:0] sensor_rd,      // Four readings
  input wire logic [31:0]  temp_limit,     // Trip level
  input wire logic         temp_limit_en,  // Trip enable
  input wire logic [15:0]  out_level,      // Stage output
  input wire logic         loop_active,    // Closed loop
  input wire logic [13:0]  prop_gain,      // Gain
  input wire logic         ramp_allowed,   // Ramp permit
  input wire logic         heater_off,     // Trip latch
  input wire logic         conv_req,       // Conversion request
  input wire logic         conv_ack,       // Conversion answer
  input wire logic         conv_to_sensor, // Conversion direction
  input wire logic [31:0]  conv_value,     // Conversion operand
  input wire logic [16:0]  ti_tenths       // Integral time
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic over;
  // Any reading above an enabled limit
  assign over = temp_limit_en && (sensor_rd[31:0] > temp_limit ||
    sensor_rd[63:32] > temp_limit || sensor_rd[95:64] > temp_limit ||
    sensor_rd[127:96] > temp_limit);
  sequence s_req;
    conv_req;
  endsequence
  sequence s_quiet;
    !conv_req [*4];
  endsequence
  a_read_idle_zero: assert property (!$past(rd_stb) |-> rdata == 32'h0)
    else $error("Read data not zero outside answer");
  a_gain_cap: assert property (prop_gain <= 14'h2710)
    else $error("Gain above range");
  a_ramp_needs_loop: assert property (ramp_allowed |-> loop_active)
    else $error("Ramp allowed without loop");
  a_trip_sets: assert property (over |=> heater_off)
    else $error("Limit trip not latched");
  a_trip_zeroes: assert property ($past(heater_off) && heater_off &&
    loop_active |-> out_level == 16'h0) else $error("Output on after trip");
  a_output_sat: assert property (loop_active |-> out_level <= 16'h2710)
    else $error("Output above full scale");
  a_conv_pulse: assert property (s_req |=> s_quiet)
    else $error("Conversion request not single");
  a_conv_hold: assert property (s_req ##1 !conv_ack [*3] |->
    $stable(conv_value) && $stable(conv_to_sensor))
    else $error("Conversion operand moved");
  a_times_read: assert property (rd_stb && addr == 3'h7 |=>
    rdata == {15'h0, $past(ti_tenths)}) else $error("Times read wrong");
  a_status_read: assert property (rd_stb && addr == 3'h6 |=>
    rdata[0] == $past(loop_active) && rdata[3] == $past(heater_off))
    else $error("Status read wrong");
endmodule // loop_param_ctrl_asserts
bind loop_param_ctrl loop_param_ctrl_asserts u_chk (.clk(clk),
  .srst(srst), .addr(addr), .rd_stb(rd_stb), .rdata(rdata),
  .sensor_rd(sensor_rd), .temp_limit(temp_limit),
  .temp_limit_en(temp_limit_en), .out_level(out_level),
  .loop_active(loop_active), .prop_gain(prop_gain),
  .ramp_allowed(ramp_allowed), .heater_off(heater_off),
  .conv_req(conv_req), .conv_ack(conv_ack),
  .conv_to_sensor(conv_to_sensor), .conv_value(conv_value),
  .ti_tenths(ti_tenths));
`default_nettype wire

//--- verif/sensor_stage_model.sv
// Purpose: Sensor channels and curve converter beside the loop block
// Assumes: Readings follow one base value, limits are fixed
// Notes:   Answer data is garbage outside the acknowledge cycle
`timescale 1ns/1ps
`default_nettype none
module sensor_stage_model (
  input  wire logic        clk,            // System clock
  input  wire logic        srst,           // Synchronous reset
  input  wire logic [31:0] base,           // Reading of input one
  input  wire logic        conv_req,       // Conversion request
  input  wire logic        conv_to_sensor, // Direction
  input  wire logic [31:0] conv_value,     // Operand
  output logic      [127:0] sensor_rd,     // Four readings
  output logic      [31:0] curve_sp_limit, // Curve limit
  output logic      [31:0] sens_min,       // Sensor low bound
  output logic      [31:0] sens_max,       // Sensor high bound
  output logic      [31:0] sens_res,       // Sensor step
  output logic      [31:0] conv_result,    // Converted value
  output logic             conv_ack        // Answer pulse
);
  // ****************************************
  // Channels and converter
  // ****************************************
  logic [2:0] dly;
  // Readings step by one per input, limits constant
  assign sensor_rd = {base + 32'h3, base + 32'h2, base + 32'h1, base};
  assign curve_sp_limit = 32'h0000C350;
  assign sens_min = 32'h00000064;
  assign sens_max = 32'h00015F90;
  assign sens_res = 32'h0000000A;
  // Answer four cycles after a request, data inverted when idle
  always @(posedge clk) begin
    conv_ack <= 1'b0;
    conv_result <= ~conv_result;
    if (srst) begin
      dly <= 3'h0;
    end else if (conv_req) begin
      dly <= 3'h4;
    end else if (dly != 3'h0) begin
      dly <= dly - 3'h1;
      if (dly == 3'h1) begin
        conv_ack <= 1'b1;
        conv_result <= conv_to_sensor ? conv_value * 2 + 7 :
          conv_value >> 1;
      end
    end
  end
endmodule // sensor_stage_model
`default_nettype wire

//--- verif/pid_loop_parameter_control_test.sv
// Purpose: Self-checking bench for the heater loop parameter block
// Assumes: Loop one, partner converter answers in four cycles
// Notes:   Random baseline, PID term, integral and readings
`timescale 1ns/1ps
`default_nettype none
`include "loop_param_defs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module pid_loop_parameter_control_test;
  logic clk = 0, srst = 1, wr_stb = 0, rd_stb = 0, temp_limit_en = 0;
  logic [2:0] addr = 3'h0, m;
  logic [31:0] wdata = 32'h0, temp_limit = 32'hFFFFFFFF, base = 32'h100, d;
  logic signed [17:0] pid_term = 18'h0;
  wire [127:0] sensor_rd;
  wire [31:0] curve_sp_limit, sens_min, sens_max, sens_res, conv_result;
  wire [31:0] conv_value, rdata, feedback_value;
  wire conv_ack, conv_req, conv_to_sensor, loop_active, integral_en;
  wire ramp_allowed, disp_power, heater_off;
  wire [15:0] out_level;
  wire [16:0] ti_tenths, td_tenths;
  wire [13:0] prop_gain;
  int failures = 0, tests_run = 0, reqs = 0, v, p, b;
  // ****************************************
  // Harness and bus tasks
  // ****************************************
  loop_param_ctrl #(.LOOP_ID(1)) dut (.clk(clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .sensor_rd(sensor_rd), .curve_sp_limit(curve_sp_limit),
    .sens_min(sens_min), .sens_max(sens_max), .sens_res(sens_res),
    .temp_limit(temp_limit), .temp_limit_en(temp_limit_en),
    .pid_term(pid_term), .conv_ack(conv_ack), .conv_result(conv_result),
    .out_level(out_level), .feedback_value(feedback_value),
    .loop_active(loop_active), .integral_en(integral_en),
    .ti_tenths(ti_tenths), .td_tenths(td_tenths), .prop_gain(prop_gain),
    .ramp_allowed(ramp_allowed), .disp_power(disp_power),
    .heater_off(heater_off), .conv_req(conv_req),
    .conv_to_sensor(conv_to_sensor), .conv_value(conv_value));
  sensor_stage_model far (.clk(clk), .srst(srst), .base(base),
    .conv_req(conv_req), .conv_to_sensor(conv_to_sensor),
    .conv_value(conv_value), .sensor_rd(sensor_rd),
    .curve_sp_limit(curve_sp_limit), .sens_min(sens_min),
    .sens_max(sens_max), .sens_res(sens_res),
    .conv_result(conv_result), .conv_ack(conv_ack));
  // Clock at 40 MHz
  initial forever #12.5 clk = ~clk;
  // Count conversion requests seen by the far side
  always @(posedge clk) if (conv_req === 1'b1) reqs <= reqs + 1;
  function logic [31:0] su(input logic [2:0] md, input logic [2:0] s,
    input logic u, input logic w);
    return {22'h0, w, u, 1'b0, s, 1'b0, md};
  endfunction
  function logic [15:0] sat(input int x);
    return x < 0 ? 16'h0 : x > 10000 ? 16'h2710 : 16'(x);
  endfunction
  function logic [31:0] ti_of(input int x);
    return x == 0 ? 32'h0 : 32'(100000 / x);
  endfunction
  task wr(input logic [2:0] a, input logic [31:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task rd(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  task rc(input logic [2:0] a, input logic [31:0] e);
    rd(a);
    `CHK(d, e)
  endtask
  task step;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Poll the busy flag under a bound
  task idle;
    for (int j = 0; j < 40; j++) begin
      rd(`ADDR_STATUS);
      if (d[4] === 1'b0) break;
    end
  endtask
  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog far beyond the expected few hundred cycles
  initial begin
    #1000000;
    failures++;
    print_verdict();
  end
  initial begin
    void'($urandom(27288));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (20) @(posedge clk);
    rc(`ADDR_HEATER_SETUP, 32'h10);
    rc(`ADDR_PROP_GAIN, 32'h1F4);
    rc(`ADDR_INTEGRAL, 32'hC8);
    rc(`ADDR_DERIVATIVE, 32'h0);
    rc(`ADDR_BASELINE_OUTPUT, 32'h0);
    rc(`ADDR_TARGET_VALUE, 32'h0);
    rc(`ADDR_TIMES, 32'h1F4);
    wr(`ADDR_PROP_GAIN, 32'hFFFF);
    rc(`ADDR_PROP_GAIN, 32'h2710);
    `CHK(prop_gain, 14'h2710)
    wr(`ADDR_BASELINE_OUTPUT, 32'h4E20);
    rc(`ADDR_BASELINE_OUTPUT, 32'h2710);
    wr(`ADDR_DERIVATIVE, 32'h12C);
    rc(`ADDR_DERIVATIVE, 32'hC8);
    // Integral edges and random values with random derivative
    for (int k = 0; k < 6; k++) begin
      v = k == 0 ? 0 : k == 1 ? 10000 : $urandom_range(10000, 1);
      p = $urandom_range(200, 0);
      wr(`ADDR_DERIVATIVE, 32'(p));
      wr(`ADDR_INTEGRAL, 32'(v));
      idle();
      rc(`ADDR_TIMES, ti_of(v));
      `CHK(ti_tenths, 17'(ti_of(v)))
      `CHK(integral_en, v != 0)
      `CHK(td_tenths, 17'(ti_of(v) * p / 400))
    end
    @(posedge clk) base <= $urandom_range(30000, 1000);
    // Closed modes with and without an input
    for (int k = 0; k < 6; k++) begin
      m = k % 3 == 0 ? `MODE_PID : k % 3 == 1 ? `MODE_ZONE : `MODE_WARMUP;
      b = $urandom_range(10000, 0);
      p = int'($urandom_range(24000, 0)) - 12000;
      @(posedge clk) pid_term <= 18'(p);
      wr(`ADDR_BASELINE_OUTPUT, 32'(b));
      wr(`ADDR_HEATER_SETUP, su(m, 3'h2, 1'b0, 1'b0));
      step();
      `CHK(out_level, sat(b + p))
      `CHK(loop_active, 1'b1)
      `CHK(feedback_value, base + 32'h1)
      wr(`ADDR_HEATER_SETUP, su(m, 3'h0, 1'b0, 1'b0));
      step();
      `CHK(loop_active, 1'b0)
      `CHK(out_level, 16'h0)
    end
    wr(`ADDR_HEATER_SETUP, su(`MODE_OPEN, 3'h0, 1'b0, 1'b1));
    step();
    `CHK(out_level, 16'(b))
    `CHK(disp_power, 1'b1)
    wr(`ADDR_HEATER_SETUP, su(`MODE_MONITOR, 3'h3, 1'b0, 1'b0));
    step();
    `CHK(out_level, 16'(base + 32'h2))
    `CHK(disp_power, 1'b0)
    wr(`ADDR_HEATER_SETUP, su(`MODE_OFF, 3'h1, 1'b0, 1'b0));
    step();
    `CHK(out_level, 16'h0)
    `CHK(feedback_value, base)
    // Setpoint clamp, unit switch and sensor bounds
    wr(`ADDR_HEATER_SETUP, su(`MODE_PID, 3'h1, 1'b0, 1'b0));
    wr(`ADDR_TARGET_VALUE, 32'hFFFFF);
    rc(`ADDR_TARGET_VALUE, 32'hC350);
    `CHK(ramp_allowed, 1'b1)
    wr(`ADDR_TARGET_VALUE, 32'h4D2);
    wr(`ADDR_HEATER_SETUP, su(`MODE_PID, 3'h1, 1'b1, 1'b0));
    for (int j = 0; j < 50 && conv_ack !== 1'b1; j++) @(posedge clk);
    step();
    `CHK(conv_value, 32'h4D2)
    `CHK(conv_to_sensor, 1'b1)
    `CHK(reqs, 1)
    rc(`ADDR_TARGET_VALUE, 32'h9A6);
    `CHK(ramp_allowed, 1'b0)
    wr(`ADDR_TARGET_VALUE, 32'h17318);
    rc(`ADDR_TARGET_VALUE, 32'h15F90);
    wr(`ADDR_TARGET_VALUE, 32'h5);
    rc(`ADDR_TARGET_VALUE, 32'h64);
    // Temperature limit trip and clear
    wr(`ADDR_BASELINE_OUTPUT, 32'h1388);
    @(posedge clk) temp_limit <= base + 32'h1;
    temp_limit_en <= 1'b1;
    step();
    `CHK(heater_off, 1'b1)
    step();
    `CHK(out_level, 16'h0)
    rc(`ADDR_STATUS, 32'hB);
    @(posedge clk) temp_limit_en <= 1'b0;
    wr(`ADDR_HEATER_SETUP, su(`MODE_PID, 3'h1, 1'b1, 1'b0));
    step();
    `CHK(heater_off, 1'b0)
    `CHK(out_level, sat(5000 + p))
    rc(`ADDR_STATUS, {sat(5000 + p), 16'h0003});
    // Back to temperature units: converted through the curve again
    wr(`ADDR_HEATER_SETUP, su(`MODE_PID, 3'h1, 1'b0, 1'b0));
    for (int j = 0; j < 50 && conv_ack !== 1'b1; j++) @(posedge clk);
    step();
    `CHK(conv_value, 32'h64)
    `CHK(conv_to_sensor, 1'b0)
    `CHK(reqs, 2)
    rc(`ADDR_TARGET_VALUE, 32'h32);
    `CHK(ramp_allowed, 1'b1)
    print_verdict();
  end
endmodule // pid_loop_parameter_control_test
`default_nettype wire
